// ### rtl/dpc_register_bank.sv
// Top: control register bank of the demodulator and synthesizer, behind the serial port
`timescale 1ns/1ps
`default_nettype none

module dpc_register_bank
  import dpc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE,
  input wire logic [DPC_BAND_W-1:0] BANDCAL_BAND,
  output dpc_ctrl_t CTRL,
  output logic [DPC_POWER_MSB:DPC_POWER_LSB] POWER_ON,
  output logic INTEGER_MODE,
  output logic PUMP_EXTERNAL_REF,
  output logic PUMP_CODE_VALID,
  output logic BLEED_SOURCE,
  output logic [DPC_BLEED_MAG_MSB:DPC_BLEED_MAG_LSB] BLEED_STEPS,
  output logic [DPC_REF_MUX_MSB-DPC_REF_MUX_LSB:0] REF_MUX_SELECT,
  output dpc_ref_ratio_t REF_RATIO,
  output logic I_INVERT,
  output logic Q_INVERT
);

  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;
  logic wr_valid;
  dpc_cmd_t wr_cmd;
  logic [DPC_ADDR_W-1:0] rd_addr;
  logic [DPC_DATA_W-1:0] rd_data;
  logic soft_reset;
  logic [DPC_DATA_W-1:0] regs_q [DPC_NREG];
  logic [DPC_NREG*DPC_DATA_W-1:0] regs_flat;
  logic [DPC_DATA_W-1:0] band_readback_q;
  logic [DPC_DATA_W-1:0] band_sel;
  logic [DPC_DATA_W-1:0] pump_reg;
  logic [DPC_DATA_W-1:0] ref_reg;
  logic [DPC_DATA_W-1:0] pol_reg;
  logic [DPC_DATA_W-1:0] div_reg;
  logic [DPC_DATA_W-1:0] pwr_reg;
  logic [3:0] pump_coarse_current;
  logic [2:0] reference_ratio_select;
  logic [1:0] i_output_polarity;
  logic [1:0] q_output_polarity;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  dpc_serial_port u_port (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .sclk(SCLK),
    .cs_n(CS_N),
    .sdio_in(SDIO_IN),
    .sdio_out(SDIO_OUT),
    .sdio_oe(SDIO_OE),
    .wr_valid(wr_valid),
    .wr_cmd(wr_cmd),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Trigger is not stored, so it reads back zero
  assign soft_reset = wr_valid && wr_cmd.addr == DPC_ADDR_SOFT_RESET_TRIGGER
                      && wr_cmd.data[DPC_SOFT_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read-write registers; reserved bits never hold a one
  for (genvar i = 0; i < DPC_NREG; i++)
  begin : g_reg
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
      if (!rst_n)
        regs_q[i] <= DPC_REG_RESET[i] & DPC_REG_MASK[i];
      else if (soft_reset)
        regs_q[i] <= DPC_REG_RESET[i] & DPC_REG_MASK[i];
      else if (wr_valid && wr_cmd.addr == DPC_REG_ADDR[i])
        regs_q[i] <= wr_cmd.data & DPC_REG_MASK[i];
    end
    assign regs_flat[(DPC_NREG-1-i)*DPC_DATA_W +: DPC_DATA_W] = regs_q[i];
  end

  assign CTRL = dpc_ctrl_t'(regs_flat);

  ////////////////////////////////////////////////////////////////////////////
  // Band readback: serial setting or calibration result, as selected
  assign band_sel = regs_q[DPC_IDX_BAND_SEL];

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
      band_readback_q <= DPC_RST_OSC_BAND_READBACK;
    else if (soft_reset)
      band_readback_q <= DPC_RST_OSC_BAND_READBACK;
    else if (band_sel[DPC_BAND_SRC_BIT])
      band_readback_q <= {{(DPC_DATA_W-DPC_BAND_W){1'b0}}, BANDCAL_BAND};
    else
      band_readback_q <= {{(DPC_DATA_W-DPC_BAND_W){1'b0}}, band_sel[DPC_BAND_W-1:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unlisted and write-only offsets read zero
  always_comb
  begin
    rd_data = DPC_RST_SOFT_RESET_TRIGGER;
    if (rd_addr == DPC_ADDR_OSC_BAND_READBACK)
      rd_data = band_readback_q;
    for (int k = 0; k < DPC_NREG; k++)
    begin
      if (rd_addr == DPC_REG_ADDR[k])
        rd_data = regs_q[k];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  assign pwr_reg = regs_q[DPC_IDX_POWER];
  assign div_reg = regs_q[DPC_IDX_INT_DIV];
  assign pump_reg = regs_q[DPC_IDX_PUMP];
  assign ref_reg = regs_q[DPC_IDX_REF];
  assign pol_reg = regs_q[DPC_IDX_POLARITY];
  assign pump_coarse_current = pump_reg[DPC_PUMP_COARSE_MSB:DPC_PUMP_COARSE_LSB];
  assign reference_ratio_select = ref_reg[DPC_REF_RATIO_MSB:DPC_REF_RATIO_LSB];
  assign i_output_polarity = pol_reg[DPC_I_POL_MSB:DPC_I_POL_LSB];
  assign q_output_polarity = pol_reg[DPC_Q_POL_MSB:DPC_Q_POL_LSB];

  // Range of the division value is left to the host; no clamping here
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      POWER_ON <= '0;
      INTEGER_MODE <= 1'b0;
    end
    else
    begin
      POWER_ON <= pwr_reg[DPC_POWER_MSB:DPC_POWER_LSB];
      INTEGER_MODE <= div_reg[DPC_DIV_MODE_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PUMP_EXTERNAL_REF <= 1'b0;
      PUMP_CODE_VALID <= 1'b0;
      BLEED_SOURCE <= 1'b0;
      BLEED_STEPS <= '0;
    end
    else
    begin
      PUMP_EXTERNAL_REF <= pump_reg[DPC_PUMP_SRC_BIT];
      PUMP_CODE_VALID <= pump_coarse_current == DPC_PUMP_250UA
                         || pump_coarse_current == DPC_PUMP_500UA
                         || pump_coarse_current == DPC_PUMP_750UA
                         || pump_coarse_current == DPC_PUMP_1000UA;
      BLEED_SOURCE <= pump_reg[DPC_BLEED_SIGN_BIT];
      BLEED_STEPS <= pump_reg[DPC_BLEED_MAG_MSB:DPC_BLEED_MAG_LSB];
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      REF_MUX_SELECT <= '0;
      REF_RATIO <= DPC_REF_TIMES_TWO;
    end
    else
    begin
      REF_MUX_SELECT <= ref_reg[DPC_REF_MUX_MSB:DPC_REF_MUX_LSB];
      unique case (reference_ratio_select)
        3'h0: REF_RATIO <= DPC_REF_TIMES_TWO;
        3'h1: REF_RATIO <= DPC_REF_TIMES_ONE;
        3'h2: REF_RATIO <= DPC_REF_DIV_2;
        3'h3: REF_RATIO <= DPC_REF_DIV_4;
        3'h4: REF_RATIO <= DPC_REF_DIV_8;
        default: REF_RATIO <= DPC_REF_ILLEGAL;
      endcase
    end
  end

  // Codes 0 and 3 are undefined; they read as normal polarity
  always_ff @(posedge REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      I_INVERT <= 1'b0;
      Q_INVERT <= 1'b0;
    end
    else
    begin
      I_INVERT <= i_output_polarity == DPC_I_POL_INVERT;
      Q_INVERT <= q_output_polarity == DPC_Q_POL_INVERT;
    end
  end

endmodule : dpc_register_bank
`default_nettype wire

// ### rtl/dpc_pkg.sv
// Package: register map, field layout and serial frame constants of the demodulator control bank
package dpc_pkg;

  // Serial frame: read flag, 7-bit address, 16-bit data, most significant bit first
  localparam int DPC_ADDR_W = 7;
  localparam int DPC_DATA_W = 16;
  localparam int DPC_HDR_BITS = 8;
  localparam int DPC_FRAME_BITS = 24;
  localparam int DPC_CNT_W = 5;
  localparam logic [DPC_CNT_W-1:0] DPC_CNT_HDR_LAST = 5'h07;
  localparam logic [DPC_CNT_W-1:0] DPC_CNT_FRAME_LAST = 5'h17;
  localparam logic [DPC_CNT_W-1:0] DPC_CNT_FULL = 5'h18;
  localparam logic [DPC_CNT_W-1:0] DPC_CNT_FIRST = 5'h00;

  // Write-only trigger and read-only band readback
  localparam logic [DPC_ADDR_W-1:0] DPC_ADDR_SOFT_RESET_TRIGGER = 7'h00;
  localparam logic [DPC_ADDR_W-1:0] DPC_ADDR_OSC_BAND_READBACK = 7'h46;
  localparam int DPC_SOFT_RESET_BIT = 0;
  localparam logic [DPC_DATA_W-1:0] DPC_RST_SOFT_RESET_TRIGGER = 16'h0000;
  localparam logic [DPC_DATA_W-1:0] DPC_RST_OSC_BAND_READBACK = 16'h0000;

  // Read-write registers, one entry each: offset, printed reset value, writable bits
  localparam int DPC_NREG = 20;
  localparam logic [DPC_ADDR_W-1:0] DPC_REG_ADDR [DPC_NREG] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h20, 7'h21, 7'h22, 7'h23, 7'h30,
    7'h31, 7'h32, 7'h33, 7'h34, 7'h40, 7'h42, 7'h43, 7'h44, 7'h45, 7'h49};
  localparam logic [DPC_DATA_W-1:0] DPC_REG_RESET [DPC_NREG] = '{
    16'hfe7f, 16'h002c, 16'h0128, 16'h0600, 16'hfe7f, 16'h0c26, 16'h0003, 16'h2a03, 16'h0000, 16'h0000,
    16'h1101, 16'h0900, 16'h0000, 16'h0b00, 16'h0010, 16'h000e, 16'h0001, 16'h0000, 16'h0000, 16'h16bd};
  localparam logic [DPC_DATA_W-1:0] DPC_REG_MASK [DPC_NREG] = '{
    16'h07fe, 16'h0fff, 16'hffff, 16'hffff, 16'h07fe, 16'h7c3f, 16'h007f, 16'h00ff, 16'h0be0, 16'h00ee,
    16'h1def, 16'h0fff, 16'hffff, 16'h0f00, 16'h007f, 16'h000f, 16'hffff, 16'h0001, 16'h00ff, 16'h3fff};

  // Entry indices used by the decode logic
  localparam int DPC_IDX_POWER = 0;
  localparam int DPC_IDX_INT_DIV = 1;
  localparam int DPC_IDX_PUMP = 5;
  localparam int DPC_IDX_REF = 6;
  localparam int DPC_IDX_POLARITY = 11;
  localparam int DPC_IDX_BAND_SEL = 18;

  // Field positions
  localparam int DPC_POWER_LSB = 1;
  localparam int DPC_POWER_MSB = 10;
  localparam int DPC_DIV_MODE_BIT = 11;
  localparam int DPC_PUMP_SRC_BIT = 14;
  localparam int DPC_PUMP_COARSE_LSB = 10;
  localparam int DPC_PUMP_COARSE_MSB = 13;
  localparam int DPC_BLEED_SIGN_BIT = 5;
  localparam int DPC_BLEED_MAG_LSB = 0;
  localparam int DPC_BLEED_MAG_MSB = 4;
  localparam int DPC_REF_MUX_LSB = 4;
  localparam int DPC_REF_MUX_MSB = 6;
  localparam int DPC_REF_RATIO_LSB = 0;
  localparam int DPC_REF_RATIO_MSB = 2;
  localparam int DPC_I_POL_LSB = 8;
  localparam int DPC_I_POL_MSB = 9;
  localparam int DPC_Q_POL_LSB = 10;
  localparam int DPC_Q_POL_MSB = 11;
  localparam int DPC_BAND_SRC_BIT = 7;
  localparam int DPC_BAND_W = 6;

  // Polarity codes
  localparam logic [1:0] DPC_I_POL_INVERT = 2'h2;
  localparam logic [1:0] DPC_Q_POL_INVERT = 2'h1;

  // Coarse pump current thermometer codes
  localparam logic [3:0] DPC_PUMP_250UA = 4'h1;
  localparam logic [3:0] DPC_PUMP_500UA = 4'h3;
  localparam logic [3:0] DPC_PUMP_750UA = 4'h7;
  localparam logic [3:0] DPC_PUMP_1000UA = 4'hf;

  typedef enum logic [2:0] {
    DPC_REF_TIMES_TWO = 3'h0,
    DPC_REF_TIMES_ONE = 3'h1,
    DPC_REF_DIV_2 = 3'h2,
    DPC_REF_DIV_4 = 3'h3,
    DPC_REF_DIV_8 = 3'h4,
    DPC_REF_ILLEGAL = 3'h7
  } dpc_ref_ratio_t;

  typedef struct packed {
    logic [DPC_ADDR_W-1:0] addr;
    logic [DPC_DATA_W-1:0] data;
  } dpc_cmd_t;

  // Register contents in entry order, first entry in the top field
  typedef struct packed {
    logic [15:0] block_power_enables;
    logic [15:0] integer_divider;
    logic [15:0] fraction_numerator;
    logic [15:0] fraction_modulus;
    logic [15:0] power_down_mask;
    logic [15:0] charge_pump_control;
    logic [15:0] reference_path_control;
    logic [15:0] oscillator_lo_control;
    logic [15:0] rf_switch_attenuator;
    logic [15:0] input_transformer_tuning;
    logic [15:0] mixer_bias_linearizer;
    logic [15:0] iq_polarity_sideband;
    logic [15:0] iq_offset_nulling;
    logic [15:0] baseband_bias_bandwidth;
    logic [15:0] phase_detector_control;
    logic [15:0] dither_control;
    logic [15:0] dither_seed;
    logic [15:0] band_calibration_clear;
    logic [15:0] oscillator_band_select;
    logic [15:0] oscillator_internal_settings;
  } dpc_ctrl_t;

endpackage : dpc_pkg

// ### rtl/dpc_serial_port.sv
// Three-wire serial port: frame capture and read data shift-out
`timescale 1ns/1ps
`default_nettype none
module dpc_serial_port
  import dpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic wr_valid,
  output dpc_cmd_t wr_cmd,
  output logic [DPC_ADDR_W-1:0] rd_addr,
  input wire logic [DPC_DATA_W-1:0] rd_data
);

  logic sclk_q;
  logic [DPC_CNT_W-1:0] cnt_q;
  logic [DPC_FRAME_BITS-2:0] in_sr_q;
  logic rd_go_q;
  logic [DPC_DATA_W-1:0] out_sr_q;
  logic rise;
  logic fall;

  // Pins are synchronous to clk, so a plain delayed copy finds the edges
  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_q <= 1'b0;
    else
      sclk_q <= sclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shifting; bits after the 24th are ignored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= DPC_CNT_FIRST;
      in_sr_q <= '0;
    end
    else if (cs_n)
      cnt_q <= DPC_CNT_FIRST;
    else if (rise && cnt_q != DPC_CNT_FULL)
    begin
      cnt_q <= cnt_q + 5'h01;
      in_sr_q <= {in_sr_q[DPC_FRAME_BITS-3:0], sdio_in};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_valid <= 1'b0;
      wr_cmd <= '0;
    end
    else
    begin
      wr_valid <= !cs_n && rise && cnt_q == DPC_CNT_FRAME_LAST && !in_sr_q[DPC_FRAME_BITS-2];
      if (!cs_n && rise && cnt_q == DPC_CNT_FRAME_LAST)
        wr_cmd <= {in_sr_q[DPC_FRAME_BITS-3:0], sdio_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read: header done, fetch word next cycle, shift out on falling edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_go_q <= 1'b0;
      rd_addr <= '0;
    end
    else
    begin
      rd_go_q <= !cs_n && rise && cnt_q == DPC_CNT_HDR_LAST && in_sr_q[DPC_HDR_BITS-2];
      if (!cs_n && rise && cnt_q == DPC_CNT_HDR_LAST)
        rd_addr <= {in_sr_q[DPC_ADDR_W-2:0], sdio_in};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sr_q <= '0;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
    end
    else if (cs_n)
      sdio_oe <= 1'b0;
    else if (rd_go_q)
    begin
      out_sr_q <= rd_data;
      sdio_oe <= 1'b1;
    end
    else if (fall && sdio_oe)
    begin
      sdio_out <= out_sr_q[DPC_DATA_W-1];
      out_sr_q <= {out_sr_q[DPC_DATA_W-2:0], 1'b0};
    end
  end

endmodule : dpc_serial_port
`default_nettype wire

// ### verification/dpc_register_bank_props.sv
// Checker: decoded outputs and register contents of the control bank
`timescale 1ns/1ps
`default_nettype none
module dpc_register_bank_props
  import dpc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire dpc_ctrl_t CTRL,
  input wire logic [DPC_POWER_MSB:DPC_POWER_LSB] POWER_ON,
  input wire logic INTEGER_MODE,
  input wire logic PUMP_EXTERNAL_REF,
  input wire logic PUMP_CODE_VALID,
  input wire logic BLEED_SOURCE,
  input wire logic [DPC_BLEED_MAG_MSB:DPC_BLEED_MAG_LSB] BLEED_STEPS,
  input wire logic [DPC_REF_MUX_MSB-DPC_REF_MUX_LSB:0] REF_MUX_SELECT,
  input wire dpc_ref_ratio_t REF_RATIO,
  input wire logic I_INVERT,
  input wire logic Q_INVERT
);
  logic [2:0] up_q;
  logic up;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // Decoded outputs read zero until the internal release has passed
  always_ff @(posedge REF_CLK or negedge RESET_N)
    if (!RESET_N)
      up_q <= 3'h0;
    else if (up_q != 3'h4)
      up_q <= up_q + 3'h1;
  assign up = (up_q == 3'h4);
  ////////////////////////////////////////////////////////////////////////
  property p_reset;
    $rose(RESET_N) |-> CTRL.block_power_enables == 16'h067e && CTRL.power_down_mask == 16'h067e
      && CTRL.integer_divider == 16'h002c && CTRL.fraction_numerator == 16'h0128 && CTRL.fraction_modulus == 16'h0600;
  endproperty
  a_reset: assert property (p_reset) else $error("reset contents wrong");
  property p_power;
    up |-> POWER_ON == $past(CTRL.block_power_enables[10:1]);
  endproperty
  a_power: assert property (p_power) else $error("power enables not followed");
  property p_mode;
    up |-> INTEGER_MODE == $past(CTRL.integer_divider[11]);
  endproperty
  a_mode: assert property (p_mode) else $error("divide mode not followed");
  property p_src;
    up |-> PUMP_EXTERNAL_REF == $past(CTRL.charge_pump_control[14]);
  endproperty
  a_src: assert property (p_src) else $error("pump source not followed");
  property p_coarse;
    up |-> PUMP_CODE_VALID == ($past(CTRL.charge_pump_control[13:10]) inside {4'h1, 4'h3, 4'h7, 4'hf});
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse code check wrong");
  property p_bleed;
    up |-> {BLEED_SOURCE, BLEED_STEPS} == $past(CTRL.charge_pump_control[5:0]);
  endproperty
  a_bleed: assert property (p_bleed) else $error("bleed not followed");
  property p_mux;
    up |-> REF_MUX_SELECT == $past(CTRL.reference_path_control[6:4]);
  endproperty
  a_mux: assert property (p_mux) else $error("reference mux not followed");
  property p_ratio;
    up |-> REF_RATIO == (($past(CTRL.reference_path_control[2:0]) > 3'h4) ? 3'h7
      : $past(CTRL.reference_path_control[2:0]));
  endproperty
  a_ratio: assert property (p_ratio) else $error("reference ratio decode wrong");
  property p_pol;
    up |-> I_INVERT == ($past(CTRL.iq_polarity_sideband[9:8]) == 2'h2)
      && Q_INVERT == ($past(CTRL.iq_polarity_sideband[11:10]) == 2'h1);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity decode wrong");
  property p_reserved;
    CTRL.integer_divider[15:12] == 4'h0 && CTRL.charge_pump_control[15] == 1'b0
      && CTRL.charge_pump_control[9:6] == 4'h0 && CTRL.reference_path_control[15:7] == 9'h000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
endmodule : dpc_register_bank_props
bind dpc_register_bank dpc_register_bank_props u_props (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CTRL(CTRL),
  .POWER_ON(POWER_ON), .INTEGER_MODE(INTEGER_MODE), .PUMP_EXTERNAL_REF(PUMP_EXTERNAL_REF),
  .PUMP_CODE_VALID(PUMP_CODE_VALID), .BLEED_SOURCE(BLEED_SOURCE), .BLEED_STEPS(BLEED_STEPS),
  .REF_MUX_SELECT(REF_MUX_SELECT), .REF_RATIO(REF_RATIO), .I_INVERT(I_INVERT), .Q_INVERT(Q_INVERT));
`default_nettype wire

// ### verification/dpc_host_model.sv
// Host model: frames on the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model (
  input wire logic clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  output logic sclk,
  output logic cs_n,
  output logic sdio_in
);
  logic drv_q = 1'b0;
  logic bit_q = 1'b0;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // Released line shows the inverse of the last bit, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (drv_q ? bit_q : ~bit_q);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Serial clock stands low outside frames
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d, input int nbits,
    output logic [15:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 16'h0000;
    cs_n = 1'b0;
    tick(1);
    for (int i = 0; i < nbits; i++)
    begin
      if (rd && i >= 8)
      begin
        drv_q = 1'b0;
        q = {q[14:0], sdio_out};
      end
      else
      begin
        drv_q = 1'b1;
        bit_q = f[23-i];
      end
      sclk = 1'b1;
      tick(3);
      sclk = 1'b0;
      tick(2);
    end
    cs_n = 1'b1;
    drv_q = 1'b0;
    tick(2);
  endtask : xfer
endmodule : dpc_host_model
`default_nettype wire

// ### verification/dpc_register_bank_tb.sv
// Testbench: register bank driven through the host model
`timescale 1ns/1ps
`default_nettype none
module dpc_register_bank_tb
  import dpc_pkg::*;
;
  typedef struct packed {logic [6:0] a; logic [15:0] d; logic [15:0] q;} dpc_row_t;
  localparam dpc_row_t ROWS [8] = '{'{7'h02, 16'hffff, 16'h0fff}, '{7'h03, 16'ha5c3, 16'ha5c3},
    '{7'h04, 16'hffff, 16'hffff}, '{7'h20, 16'hffff, 16'h7c3f}, '{7'h21, 16'hffff, 16'h007f},
    '{7'h01, 16'h0000, 16'h0000}, '{7'h10, 16'hffff, 16'h07fe}, '{7'h32, 16'hffff, 16'h0fff}};
  localparam logic [3:0] COARSE [5] = '{4'h1, 4'h3, 4'h7, 4'hf, 4'h5};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] band = 6'h2a;
  logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, int_mode, pump_ext, pump_ok, bleed_src, i_inv, q_inv;
  dpc_ctrl_t ctrl;
  logic [10:1] power_on;
  logic [4:0] bleed_steps;
  logic [2:0] ref_mux;
  dpc_ref_ratio_t ref_ratio;
  logic [15:0] q;
  int fails = 0;
  int comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  dpc_register_bank u_dpc_register_bank (.REF_CLK(ref_clk), .RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n),
    .SDIO_IN(sdio_in), .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe), .BANDCAL_BAND(band), .CTRL(ctrl),
    .POWER_ON(power_on), .INTEGER_MODE(int_mode), .PUMP_EXTERNAL_REF(pump_ext), .PUMP_CODE_VALID(pump_ok),
    .BLEED_SOURCE(bleed_src), .BLEED_STEPS(bleed_steps), .REF_MUX_SELECT(ref_mux), .REF_RATIO(ref_ratio),
    .I_INVERT(i_inv), .Q_INVERT(q_inv));
  dpc_host_model u_dpc_host_model (.clk(ref_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sclk(sclk),
    .cs_n(cs_n), .sdio_in(sdio_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] unused;
    u_dpc_host_model.xfer(1'b0, a, d, 24, unused);
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    u_dpc_host_model.xfer(1'b1, a, 16'h0000, 24, v);
    check(v, e);
  endtask : rdc
  task automatic restart();
    reset_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : restart
  task automatic finish_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    restart();
    check(16'(power_on), 16'h033f);
    check(16'(ref_ratio), 16'h0003);
    check({8'h00, pump_ok, pump_ext, bleed_src, bleed_steps}, 16'h00a6);
    check({13'h0, i_inv, q_inv, int_mode}, 16'h0000);
    for (int i = 0; i < DPC_NREG; i++)
      rdc(DPC_REG_ADDR[i], DPC_REG_RESET[i] & DPC_REG_MASK[i]);
    rdc(7'h00, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].q);
    end
    check({8'h00, pump_ok, pump_ext, bleed_src, bleed_steps}, 16'h00ff);
    check({10'h0, ref_mux, ref_ratio}, 16'h003f);
    check(16'(power_on), 16'h0000);
    wr(7'h02, 16'h087b);
    check(16'(int_mode), 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      wr(7'h21, 16'(i));
      check(16'(ref_ratio), (i < 5) ? 16'(i) : 16'h0007);
    end
    // Last code is not a thermometer code
    for (int i = 0; i < 5; i++)
    begin
      wr(7'h20, {2'b00, COARSE[i], 10'h000});
      check(16'(pump_ok), 16'(i < 4));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(7'h32, {4'h0, i[1] ? 2'h1 : 2'h2, i[0] ? 2'h2 : 2'h1, 8'h00});
      check({14'h0, i_inv, q_inv}, {14'h0, i[0], i[1]});
    end
    // Short frame, read-only and unlisted offsets leave state alone
    u_dpc_host_model.xfer(1'b0, 7'h03, 16'h1234, 20, q);
    wr(7'h46, 16'hffff);
    wr(7'h05, 16'hffff);
    rdc(7'h03, 16'ha5c3);
    rdc(7'h05, 16'h0000);
    wr(7'h45, 16'h0095);
    rdc(7'h46, 16'h002a);
    wr(7'h45, 16'h0015);
    rdc(7'h46, 16'h0015);
    wr(7'h00, 16'hfffe);
    rdc(7'h03, 16'ha5c3);
    wr(7'h00, 16'h0001);
    rdc(7'h03, 16'h0128);
    rdc(7'h04, 16'h0600);
    rdc(7'h02, 16'h002c);
    wr(7'h20, 16'h4000);
    restart();
    rdc(7'h20, 16'h0c26);
    finish_test();
  end
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
endmodule : dpc_register_bank_tb
`default_nettype wire
